// ---- verilog/spim_pkg.sv ----
package spim_pkg;
  // register byte addresses on the apb bus
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_DATA   = 12'h008;
  // control register fields
  localparam int CTRL_RATE0  = 0;
  localparam int CTRL_RATE1  = 1;
  localparam int CTRL_PHASE  = 2;
  localparam int CTRL_IDLE   = 3;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_PORTEN = 6;
  localparam int CTRL_IRQEN  = 7;
  localparam int CTRL_IMASK  = 8;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  // status register fields
  localparam int STAT_FAULT = 4;
  localparam int STAT_COLL  = 6;
  localparam int STAT_DONE  = 7;
  // half sck period in cpu clocks for each rate code
  // fastest half period must cover the two-flop miso delay plus one
  localparam logic [7:0] HALF_DIV0 = 8'h04;
  localparam logic [7:0] HALF_DIV1 = 8'h08;
  localparam logic [7:0] HALF_DIV2 = 8'h10;
  localparam logic [7:0] HALF_DIV3 = 8'h40;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LEAD  = 3'b010,
    ST_TRAIL = 3'b100
  } spim_state_t;
endpackage

// ---- verilog/spim_core.sv ----
// Behaviour
// - full duplex, one bit per sck, most significant bit first
// - master drives sck and mosi, samples miso
// - slave takes sck from pin, samples mosi, drives miso
// - master transfer starts on a data register write
// - data write loads the 8-bit shifter which shifts out msb first
// - a byte is exactly eight sck pulses, shifting in and out together
// - done flag sets at byte end; irq when enabled and not masked
// - received byte copied to read buffer as done sets; data reads return it
// - done clears after status access while set, then a data read
// - data writes ignored while done set until status is read
// - rate bits have no effect in slave mode
// - slave transfer begins with sck edges from the master
// - master stays enabled only while select input is high
// - master clear and port enable set gives slave mode on pins
// - idle level bit sets sck level outside transfers
// - phase set: second edge captures msb
// - phase clear: first edge captures msb
// - master presents each bit one edge before its capture edge
// - slave data register frozen against writes while select is low
// - slave handles sck up to about a quarter of the cpu clock
// - write during transfer discarded, sets collision flag, no irq
// - select low in master mode sets fault, clears enable and master
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module spim_core
  import spim_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        ss_n,
  output logic             irq
);
  logic [8:0]  ctrl;
  logic        done_flag;
  logic        coll_flag;
  logic        fault_flag;
  logic        done_armed;
  logic        fault_armed;
  logic [7:0]  shifter;
  logic [7:0]  rx_buf;
  logic        tx_bit;
  logic [3:0]  bit_cnt;
  logic [7:0]  div_cnt;
  spim_state_t state;
  logic        sck_q1, sck_q2, sck_q3;
  logic        mosi_q1, mosi_q2;
  logic        miso_q1, miso_q2;
  logic        ss_q1, ss_q2;

  // control fields decoded once
  logic master, enabled, phase, idle_lvl;
  assign master   = ctrl[CTRL_MASTER];
  assign enabled  = ctrl[CTRL_PORTEN];
  assign phase    = ctrl[CTRL_PHASE];
  assign idle_lvl = ctrl[CTRL_IDLE];

  // apb access phase and address decode
  logic acc, wr, rd, hit_ctrl, hit_stat, hit_data;
  assign acc      = psel && penable;
  assign wr       = acc && pwrite;
  assign rd       = acc && !pwrite;
  assign hit_ctrl = paddr == ADDR_CTRL;
  assign hit_stat = paddr == ADDR_STATUS;
  assign hit_data = paddr == ADDR_DATA;

  // two flops on every pin before use
  // the slave rate is limited by this delay, about a quarter of clk
  // select resets high so a cold start never looks selected
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_q1  <= 1'b0;
      sck_q2  <= 1'b0;
      sck_q3  <= 1'b0;
      mosi_q1 <= 1'b0;
      mosi_q2 <= 1'b0;
      miso_q1 <= 1'b0;
      miso_q2 <= 1'b0;
      ss_q1   <= 1'b1;
      ss_q2   <= 1'b1;
    end else begin
      sck_q1  <= sck_in;
      sck_q2  <= sck_q1;
      sck_q3  <= sck_q2;
      mosi_q1 <= mosi_in;
      mosi_q2 <= mosi_q1;
      miso_q1 <= miso_in;
      miso_q2 <= miso_q1;
      ss_q1   <= ss_n;
      ss_q2   <= ss_q1;
    end
  end

  // slave edges: leading edge leaves idle level, trailing edge returns
  logic s_edge, s_lead, s_trail, slave_on, slave_sel;
  assign slave_on  = enabled && !master;
  assign slave_sel = slave_on && !ss_q2;
  assign s_edge    = slave_sel && (sck_q2 != sck_q3);
  assign s_lead    = s_edge && (sck_q2 != idle_lvl);
  assign s_trail   = s_edge && (sck_q2 == idle_lvl);

  // master half period tick; rate only ever read in master mode
  logic [7:0] half_div;
  always_comb begin
    case (ctrl[CTRL_RATE1:CTRL_RATE0])
      2'b00:   half_div = HALF_DIV0;
      2'b01:   half_div = HALF_DIV1;
      2'b10:   half_div = HALF_DIV2;
      default: half_div = HALF_DIV3;
    endcase
  end

  // counter reloads while idle so each byte starts on a full half period
  logic m_tick, m_busy;
  assign m_busy = master && state != ST_IDLE;
  assign m_tick = m_busy && div_cnt == 8'h01;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 8'h00;
    end else if (!m_busy || m_tick) begin
      div_cnt <= half_div;
    end else begin
      div_cnt <= div_cnt - 8'h01;
    end
  end


  // master events come from the divider, slave events from the pin
  logic lead_ev, trail_ev, busy, start_m, fault_ev;
  assign lead_ev  = master ? (m_tick && state == ST_LEAD) : s_lead;
  assign trail_ev = master ? (m_tick && state == ST_TRAIL) : s_trail;
  assign busy     = state != ST_IDLE;
  assign fault_ev = master && enabled && !ss_q2;


  // writes are refused during a byte, while done waits, or slave selected
  logic data_wr, wr_block, wr_ok;
  assign data_wr  = wr && hit_data;
  assign wr_block = busy || (done_flag && !done_armed) || slave_sel;
  assign wr_ok    = data_wr && !wr_block;
  assign start_m  = wr_ok && master && enabled;


  // capture edge is lead when phase clear, trail when phase set
  logic cap_ev, shf_ev, last_bit;
  assign cap_ev   = phase ? trail_ev : lead_ev;
  assign shf_ev   = phase ? lead_ev : trail_ev;
  assign last_bit = bit_cnt == BITS_PER_BYTE - 4'h1;
  // master listens on miso, slave on mosi
  logic in_bit;
  assign in_bit = master ? miso_q2 : mosi_q2;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      // a fault, disable or slave deselect abandons the byte at once
    end else if (fault_ev || !enabled || (!master && ss_q2)) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_m || s_lead) begin
            state <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (lead_ev) begin
            state <= ST_TRAIL;
          end
        end
        ST_TRAIL: begin
          if (trail_ev) begin
            state <= (bit_cnt == BITS_PER_BYTE) ? ST_IDLE : ST_LEAD;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end


  // slave first lead edge arrives in idle, so count it there too
  logic lead_any;
  assign lead_any = lead_ev || (state == ST_IDLE && s_lead);

  logic cap_any;
  assign cap_any = phase ? trail_ev : lead_any;
  logic byte_end;
  assign byte_end = trail_ev && state == ST_TRAIL && bit_cnt == BITS_PER_BYTE;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= 4'h0;
    end else if (!busy && !s_lead) begin
      bit_cnt <= 4'h0;
    end else if (lead_any) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // shifter: capture into lsb, out bit is msb held in tx_bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shifter <= 8'h00;
      tx_bit  <= 1'b0;
    end else if (wr_ok) begin
      shifter <= pwdata[7:0];
      tx_bit  <= pwdata[7];
    end else if (cap_any) begin
      shifter <= {shifter[6:0], in_bit};
      // out bit moves on the shift edge, so it leads capture by one edge
    end else if (shf_ev) begin
      tx_bit  <= shifter[7];
    end else if (phase && lead_any && bit_cnt == 4'h0) begin
      tx_bit  <= shifter[7];
    end
  end


  // receive buffer and done flag
  logic done_set;
  assign done_set = byte_end && !phase ? 1'b1 : byte_end;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_buf <= 8'h00;
    end else if (done_set) begin
      // with phase set the last capture and byte end share one edge
      rx_buf <= phase ? {shifter[6:0], in_bit} : shifter;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_flag  <= 1'b0;
      done_armed <= 1'b0;
    end else if (done_set) begin
      done_flag  <= 1'b1;
      done_armed <= 1'b0;
      // status access arms the clear; a data read completes it
    end else if (acc && hit_stat && done_flag) begin
      done_armed <= 1'b1;
    end else if (rd && hit_data && done_armed) begin
      done_flag  <= 1'b0;
      done_armed <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      coll_flag <= 1'b0;
      // collision flag only reports; it never reaches irq
    end else if (data_wr && busy) begin
      coll_flag <= 1'b1;
    end else if (rd && hit_data && coll_flag) begin
      coll_flag <= 1'b0;
    end
  end


  // fault clears on status access then control write; set wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_flag  <= 1'b0;
      fault_armed <= 1'b0;
    end else if (fault_ev) begin
      fault_flag  <= 1'b1;
      fault_armed <= 1'b0;
    end else if (acc && hit_stat && fault_flag) begin
      fault_armed <= 1'b1;
    end else if (wr && hit_ctrl && fault_armed) begin
      fault_flag  <= 1'b0;
      fault_armed <= 1'b0;
    end
  end


  // master and enable stay low until the fault clear sequence starts
  logic [8:0] ctrl_wr;
  always_comb begin
    ctrl_wr = pwdata[8:0];
    if (fault_flag && !fault_armed) begin
      ctrl_wr[CTRL_MASTER] = 1'b0;
      ctrl_wr[CTRL_PORTEN] = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
    end else if (fault_ev) begin
      ctrl[CTRL_MASTER] <= 1'b0;
      ctrl[CTRL_PORTEN] <= 1'b0;
    end else if (wr && hit_ctrl) begin
      ctrl <= ctrl_wr;
    end
  end


  // pins: sck idles at the idle level, toggles per half period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_out  <= 1'b0;
      sck_oe   <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      sck_oe   <= master && enabled;
      mosi_oe  <= master && enabled;
      miso_oe  <= slave_sel;
      sck_out  <= (state == ST_TRAIL) ? !idle_lvl : idle_lvl;
      mosi_out <= tx_bit;
      miso_out <= tx_bit;
    end
  end


  // apb read mux, always ready, unmapped gives error
  // read data is registered in setup so it stands through the access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(hit_ctrl || hit_stat || hit_data);
      if (psel && !penable && hit_ctrl) begin
        prdata <= {23'h0, ctrl};
      end else if (psel && !penable && hit_stat) begin
        prdata <= {24'h0, done_flag, coll_flag, 1'b0, fault_flag, 4'h0};
      end else if (psel && !penable && hit_data) begin
        prdata <= {24'h0, rx_buf};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      // both events share one line, as they share one vector
      irq <= ctrl[CTRL_IRQEN] && !ctrl[CTRL_IMASK]
             && (done_flag || fault_flag);
    end
  end
endmodule
`default_nettype wire

// ---- dv/spim_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module spim_chk
  import spim_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sck_oe,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        ss_n,
  input wire logic        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic mapped;
  assign mapped = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_DATA};
  chk_ready_now: assert property (psel && penable |-> pready)
    else $error("no pready in access cycle");
  chk_ready_cause: assert property (pready |-> psel && penable)
    else $error("pready outside access cycle");
  chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not flagged");
  chk_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access flagged");
  chk_read_width: assert property (pready && !pwrite && mapped
    && paddr != ADDR_CTRL |-> prdata[31:8] == 24'h00_0000)
    else $error("read data wider than a byte");
  chk_master_pins: assert property (sck_oe |-> mosi_oe && !miso_oe)
    else $error("master pin drive mismatch");
  chk_slave_pins: assert property (miso_oe |-> !sck_oe && !mosi_oe)
    else $error("slave pin drive mismatch");
  // sync delay on select input allows a few cycles of latency
  chk_fault_stop: assert property (sck_oe && !ss_n ##1 !ss_n [*3]
    |-> ##[0:4] !sck_oe)
    else $error("master kept pins after select low");
  chk_reset_quiet: assert property ($rose(nrst)
    |-> !sck_oe && !miso_oe && !irq)
    else $error("pins driven right after reset");
endmodule
bind spim_core spim_chk u_chk (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
  .miso_oe(miso_oe), .ss_n(ss_n), .irq(irq));
`default_nettype wire

// ---- dv/spim_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module spim_peer (
  input  wire logic       sck,
  input  wire logic       clock_idle_level,
  input  wire logic       clock_phase_select,
  input  wire logic       mosi,
  input  wire logic       load,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic      [7:0] got
);
  logic [7:0] sh;
  logic       first;
  assign miso = sh[7];
  always @(posedge load) begin
    sh = tx;
    first = 1'b1;
  end
  // capture edge is leading for phase clear, trailing for phase set
  always @(sck) begin
    if ((sck != clock_idle_level) != clock_phase_select) begin
      got = {got[6:0], mosi};
    end else if (!clock_phase_select || !first) begin
      sh = {sh[6:0], ~sh[0]};
    end
    if (sck != clock_idle_level) begin
      first = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
  import spim_pkg::*;
;
  typedef struct {
    logic [8:0] ctl;
    logic [7:0] tx;
    logic [7:0] rx;
    logic       irq;
  } spim_row_t;
  logic        clk, nrst, psel, penable, pwrite, ss_n, load;
  logic        clock_idle_level, clock_phase_select, sck_m, mosi_m, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [7:0]  ptx, sgot;
  wire  [31:0] prdata;
  wire  [7:0]  pgot;
  wire         pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe;
  wire         miso_out, miso_oe, irq, miso_p;
  wire         sck_w  = sck_oe ? sck_out : sck_m;
  wire         mosi_w = mosi_oe ? mosi_out : mosi_m;
  wire         miso_w = miso_oe ? miso_out : miso_p;
  int          miscompares = 0, total_checks = 0, cycles = 0, n;
  spim_row_t   rows [5];
  localparam logic [7:0] SLV_BYTE = 8'h2D;
  spim_core dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_in(sck_w), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_n(ss_n), .irq(irq));
  spim_peer peer (.sck(sck_w), .clock_idle_level(clock_idle_level), .clock_phase_select(clock_phase_select), .mosi(mosi_w),
    .load(load), .tx(ptx), .miso(miso_p), .got(pgot));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("Error %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_done();
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, '0);
      n++;
    end while (rd[STAT_DONE] !== 1'b1 && n < 600);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    rows[0] = '{9'h050, 8'hA5, 8'h3C, 1'b0};
    rows[1] = '{9'h055, 8'h80, 8'h01, 1'b0};
    rows[2] = '{9'h05A, 8'h01, 8'hFE, 1'b0};
    rows[3] = '{9'h0DF, 8'h7E, 8'h81, 1'b1};
    rows[4] = '{9'h1D0, 8'hC3, 8'h5A, 1'b0};
    {psel, penable, pwrite, load, clock_idle_level, clock_phase_select, sck_m, mosi_m, nrst} = '0;
    ss_n = 1'b1;
    paddr = '0;
    pwdata = '0;
    ptx = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, ADDR_CTRL, '0);
    cmp(rd, {23'h0, CTRL_RESET});
    apb(1'b0, 12'h00C, '0);
    cmp(err, 1'b1);
    foreach (rows[i]) begin
      clock_idle_level <= rows[i].ctl[CTRL_IDLE];
      clock_phase_select <= rows[i].ctl[CTRL_PHASE];
      apb(1'b1, ADDR_CTRL, {23'h0, rows[i].ctl});
      apb(1'b0, ADDR_CTRL, '0);
      cmp(rd, {23'h0, rows[i].ctl});
      cmp(sck_out, rows[i].ctl[CTRL_IDLE]);
      ptx <= rows[i].rx;
      load <= 1'b1;
      apb(1'b1, ADDR_DATA, {24'h0, rows[i].tx});
      load <= 1'b0;
      wait_done();
      cmp(irq, rows[i].irq);
      apb(1'b0, ADDR_DATA, '0);
      cmp(rd, {24'h0, rows[i].rx});
      cmp(pgot, rows[i].tx);
      apb(1'b0, ADDR_STATUS, '0);
      cmp(rd[STAT_DONE], 1'b0);
    end
    // collision, then a write while done is still pending
    apb(1'b1, ADDR_CTRL, 32'h0000_00D0);
    ptx <= 8'h81;
    load <= 1'b1;
    apb(1'b1, ADDR_DATA, 32'h0000_0096);
    load <= 1'b0;
    apb(1'b1, ADDR_DATA, 32'h0000_0069);
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    apb(1'b1, ADDR_DATA, 32'h0000_005A);
    repeat (40) @(posedge clk);
    cmp(pgot, 8'h96);
    apb(1'b0, ADDR_STATUS, '0);
    cmp(rd[7:0], 8'hC0);
    apb(1'b0, ADDR_DATA, '0);
    cmp(rd, 32'h0000_0081);
    apb(1'b0, ADDR_STATUS, '0);
    cmp({rd[7:0], irq}, 9'h000);
    apb(1'b1, ADDR_CTRL, 32'h0000_0050);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    cmp(sck_oe, 1'b0);
    apb(1'b0, ADDR_STATUS, '0);
    cmp(rd[STAT_FAULT], 1'b1);
    ss_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, '0);
    cmp(rd[6:4], 3'h0);
    // slave, phase set, slowest rate code that must be ignored
    apb(1'b1, ADDR_CTRL, 32'h0000_0047);
    apb(1'b1, ADDR_DATA, 32'h0000_00B4);
    ss_n <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b1, ADDR_DATA, 32'h0000_00FF);
    for (int i = 0; i < 16; i++) begin
      if (i % 2 == 0) begin
        sck_m <= 1'b1;
        mosi_m <= SLV_BYTE[7 - i / 2];
      end else begin
        sgot = {sgot[6:0], miso_out};
        sck_m <= 1'b0;
      end
      repeat (i % 4 == 3 ? 7 : 6) @(posedge clk);
    end
    mosi_m <= ~mosi_m;
    ss_n <= 1'b1;
    wait_done();
    apb(1'b0, ADDR_DATA, '0);
    cmp(rd, 32'h0000_002D);
    cmp(sgot, 8'hB4);
    tally_and_finish();
  end
endmodule
`default_nettype wire
